// file: pkg/ftc_regs.svh
// Register offsets, field positions, reset values and decode constants of the translation block.
`ifndef FTC_REGS_SVH
`define FTC_REGS_SVH
`define FTC_ADDR_W          16
`define FTC_DATA_W          8
`define FTC_OFS_CTRL        16'h0301
`define FTC_OFS_A_FB        16'h0302
`define FTC_OFS_B_REF       16'h0303
`define FTC_OFS_B_FB        16'h0304
`define FTC_CTRL_DBL_B_BIT  5
`define FTC_CTRL_DBL_A_BIT  4
`define FTC_CTRL_SCALE_MSB  3
`define FTC_CTRL_SCALE_LSB  0
`define FTC_CTRL_USED_MASK  8'h3F
`define FTC_RST_CTRL        8'h00
`define FTC_RST_DIV         8'h00
`define FTC_SCALE_OFF       4'h0
`define FTC_SCALE_BYPASS    4'h1
`define FTC_SCALE_DBL_MIN   4'h8
`define FTC_DIV_BYPASS      8'h00
`define FTC_FB_MIN          8'h08
`define FTC_FB_MAX          8'h50
`define FTC_FB_DBL_MIN      8'h0F
`define FTC_FB_DBL_MAX      8'hA1
`define FTC_BREF_MIN_NOA    8'h02
`define FTC_BREF_MAX_NOA    8'h0A
`endif

// file: pkg/ftc_pkg.sv
// Types shared by the translation configuration block.
package ftc_pkg;
    // Reference prescaler mode decoded from the scaling field.
    typedef enum logic [3:0] {
        FTC_REF_OFF    = 4'h0,
        FTC_REF_BYPASS = 4'h1,
        FTC_REF_DIV1P5 = 4'h2,
        FTC_REF_DIV2   = 4'h3,
        FTC_REF_DIV3   = 4'h4,
        FTC_REF_DIV4   = 4'h5,
        FTC_REF_DIV6   = 4'h6,
        FTC_REF_DIV8   = 4'h7,
        FTC_REF_MUL2   = 4'h8
    } ftc_ref_mode_t;
    // Half-step ratio code: ratio times two, so 1.5 is exact.
    typedef logic [4:0] ftc_half_ratio_t;
endpackage

// file: design/ftc_ref_decode.sv
// Decoder from the reference scaling field to prescaler mode and ratio.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_regs.svh"
module ftc_ref_decode (
    input  wire logic                   clk_sys,
    input  wire logic                   rst,
    input  wire logic [3:0]             scaleCode,
    output var  ftc_pkg::ftc_ref_mode_t refMode,
    output var  ftc_pkg::ftc_half_ratio_t halfRatio,
    output var  logic                   refEnable
);
    import ftc_pkg::*;

    // Registered decode so the outputs come straight from flip-flops.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            refMode   <= FTC_REF_OFF;
            halfRatio <= 5'h00;
            refEnable <= 1'b0;
        end else begin
            refEnable <= (scaleCode != `FTC_SCALE_OFF); // R3
            case (scaleCode)
                4'h0: begin
                    refMode   <= FTC_REF_OFF; // R3
                    halfRatio <= 5'h00;
                end
                4'h1: begin
                    refMode   <= FTC_REF_BYPASS; // R3
                    halfRatio <= 5'h02;
                end
                4'h2: begin
                    refMode   <= FTC_REF_DIV1P5; // R4
                    halfRatio <= 5'h03;
                end
                4'h3: begin
                    refMode   <= FTC_REF_DIV2; // R4
                    halfRatio <= 5'h04;
                end
                4'h4: begin
                    refMode   <= FTC_REF_DIV3; // R4
                    halfRatio <= 5'h06;
                end
                4'h5: begin
                    refMode   <= FTC_REF_DIV4; // R4
                    halfRatio <= 5'h08;
                end
                4'h6: begin
                    refMode   <= FTC_REF_DIV6; // R4
                    halfRatio <= 5'h0C;
                end
                4'h7: begin
                    refMode   <= FTC_REF_DIV8; // R4
                    halfRatio <= 5'h10;
                end
                default: begin
                    // Codes eight through fifteen all double the reference.
                    refMode   <= FTC_REF_MUL2; // R5
                    halfRatio <= 5'h01;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// file: design/ftc_div_stage.sv
// One eight-bit divider setting with bypass decode and legal-range check.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_regs.svh"
module ftc_div_stage (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [7:0] divValue,
    input  wire logic       altRange,
    input  wire logic [7:0] loMin,
    input  wire logic [7:0] loMax,
    input  wire logic [7:0] hiMin,
    input  wire logic [7:0] hiMax,
    output var  logic       bypass,
    output var  logic [7:0] ratio,
    output var  logic       outOfRange
);
    // Registered decode; a zero value bypasses, else divides by the value.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bypass     <= 1'b1;
            ratio      <= 8'h00;
            outOfRange <= 1'b0;
        end else begin
            bypass <= (divValue == `FTC_DIV_BYPASS);
            ratio  <= divValue;
            // Bypass is always legal; otherwise the selected window applies.
            if (divValue == `FTC_DIV_BYPASS) begin
                outOfRange <= 1'b0;
            end else if (altRange) begin
                outOfRange <= (divValue < hiMin) || (divValue > hiMax);
            end else begin
                outOfRange <= (divValue < loMin) || (divValue > loMax);
            end
        end
    end
endmodule
`default_nettype wire

// file: design/ftc_translation_cfg.sv
// Frequency translation configuration registers of the third clock channel.
// Function
// R1: Control bit five enables stage B doubler.
// R2: Control bit four enables stage A doubler.
// R3: Scale code zero disables, one bypasses prescaler.
// R4: Codes two to seven divide by table.
// R5: Codes eight to fifteen double the reference.
// R6: Stage A feedback zero bypasses, else divides.
// R7: Stage B reference zero bypasses, else divides.
// R8: Stage B feedback zero bypasses, else divides.
// R9: Control bits seven and six read zero.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_regs.svh"
module ftc_translation_cfg (
    input  wire logic                     clk_sys,
    input  wire logic                     rst,
    input  wire logic [15:0]              regAddr,
    input  wire logic [7:0]               regWdata,
    input  wire logic                     regWrite,
    input  wire logic                     regRead,
    output var  logic [7:0]               regRdata,
    output var  logic                     regRvalid,
    output var  logic                     regHit,
    output var  logic                     stage_a_vco_doubler_en,
    output var  logic                     stage_b_vco_doubler_en,
    output var  ftc_pkg::ftc_ref_mode_t   refMode,
    output var  ftc_pkg::ftc_half_ratio_t refHalfRatio,
    output var  logic                     refEnable,
    output var  logic                     stageABypass,
    output var  logic [7:0]               stageAFbRatio,
    output var  logic                     stageBRefBypass,
    output var  logic [7:0]               stageBRefRatio,
    output var  logic                     stageBBypass,
    output var  logic [7:0]               stageBFbRatio,
    output var  logic                     cfgOutOfRange
);
    import ftc_pkg::*;

    // Four byte-wide registers sit at consecutive addresses on the register port.
    // The control register holds the two loop doubler enables and the four-bit
    // reference scaling field; its top two bits are not stored at all.
    // The three divider registers keep whatever software writes, legal or not.
    // Every decoded output is registered once more, in its decoder or in the doubler stage, so a
    // write shows on the outputs one cycle after the register itself changes.
    // The range warning is a further stage behind, two cycles after the write.
    // Nothing here stops a clock or gates a divider; the analogue side reads
    // these outputs and must tolerate a change on any cycle.
    // The registers clear to zero in reset, since no other value is defined.
    // With zero in every field the reference input is off and every stage is
    // bypassed, which is the quietest state the loops can be left in.

    // Stored register values and the per-stage window results.
    logic [7:0] ctrl_r;        // Translation control: doublers and scaling field.
    logic [7:0] aFb_r;         // Stage A feedback divider value.
    logic [7:0] bRef_r;        // Stage B reference divider value.
    logic [7:0] bFb_r;         // Stage B feedback divider value.
    logic       aRange;        // Stage A value outside its legal window.
    logic       bRefRange;     // Stage B reference value outside its window.
    logic       bFbRange;      // Stage B feedback value outside its window.
    logic       aFbNonZero;    // Stage A feedback field is not zero.

    // Register writes; unused control bits are masked so they never store.
    // A write takes effect at the edge where the strobe is high, so two writes
    // on consecutive cycles land one after the other with nothing lost.
    // Addresses outside the map fall through to the default branch untouched.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_r <= `FTC_RST_CTRL;
            aFb_r  <= `FTC_RST_DIV;
            bRef_r <= `FTC_RST_DIV;
            bFb_r  <= `FTC_RST_DIV;
        end else if (regWrite) begin
            case (regAddr)
                // Control: the top two bits are dropped before they are stored.
                `FTC_OFS_CTRL:  ctrl_r <= regWdata & `FTC_CTRL_USED_MASK; // R9
                // Stage A feedback value, stored whole; zero means bypass.
                `FTC_OFS_A_FB:  aFb_r  <= regWdata;
                // Stage B reference value, stored whole; zero means bypass.
                `FTC_OFS_B_REF: bRef_r <= regWdata;
                // Stage B feedback value, stored whole; zero means bypass.
                `FTC_OFS_B_FB:  bFb_r  <= regWdata;
                default: begin
                    // Writes outside the block's addresses are ignored.
                end
            endcase
        end
    end

    // Read port: data one cycle after the strobe, zero for unmapped addresses.
    // Read data and hit flag hold between reads so software may sample late.
    // A read in the same cycle as a write to the same address returns the old
    // value, because the register has not yet taken the new byte at that edge.
    // The valid flag is a plain copy of the strobe, one cycle late, and lasts as long as the strobe.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            regRdata  <= 8'h00;
            regRvalid <= 1'b0;
            regHit    <= 1'b0;
        end else begin
            regRvalid <= regRead;
            // Only a read strobe updates data and hit; idle cycles leave them.
            if (regRead) begin
                case (regAddr)
                    // Control reads back with its unused top bits forced to zero.
                    `FTC_OFS_CTRL: begin
                        regRdata <= ctrl_r & `FTC_CTRL_USED_MASK; // R9
                        regHit   <= 1'b1;
                    end
                    // Stage A feedback value as written.
                    `FTC_OFS_A_FB: begin
                        regRdata <= aFb_r;
                        regHit   <= 1'b1;
                    end
                    // Stage B reference value as written.
                    `FTC_OFS_B_REF: begin
                        regRdata <= bRef_r;
                        regHit   <= 1'b1;
                    end
                    // Stage B feedback value as written.
                    `FTC_OFS_B_FB: begin
                        regRdata <= bFb_r;
                        regHit   <= 1'b1;
                    end
                    // Unmapped addresses read zero and clear the hit flag.
                    default: begin
                        regRdata <= 8'h00;
                        regHit   <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Doubler enables follow their control bits with one register stage.
    // Each doubler changes the loop's oscillator range, so the feedback window
    // that the range check applies moves with it in the same cycle.
    // Both enables clear in reset, leaving the loops at their plain rates.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stage_a_vco_doubler_en <= 1'b0;
            stage_b_vco_doubler_en <= 1'b0;
        end else begin
            stage_a_vco_doubler_en <= ctrl_r[`FTC_CTRL_DBL_A_BIT]; // R2
            stage_b_vco_doubler_en <= ctrl_r[`FTC_CTRL_DBL_B_BIT]; // R1
        end
    end

    // Reference prescaler decode.
    // The four scaling bits go to a decoder that names the prescaler mode and
    // gives the ratio in half steps, so the divide by one and a half is exact.
    // Codes eight to fifteen all mean doubling; only the top bit is looked at.
    // Code zero also drops the reference enable, switching the input off.
    ftc_ref_decode u_ref (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .scaleCode (ctrl_r[`FTC_CTRL_SCALE_MSB:`FTC_CTRL_SCALE_LSB]),
        .refMode   (refMode),
        .halfRatio (refHalfRatio),
        .refEnable (refEnable)
    );

    // Stage B's reference window depends on whether stage A is in the path:
    // with stage A bypassed the reference divider sees the raw input and needs
    // only a small ratio, otherwise it works on stage A's output.
    assign aFbNonZero = (aFb_r != `FTC_DIV_BYPASS);

    // Stage A feedback; window depends on the stage A doubler.
    // The doubler widens the usable window because the oscillator runs faster.
    // The stored value reaches the ratio output even when it lies outside.
    ftc_div_stage u_a_fb ( // R6
        .clk_sys    (clk_sys),
        .rst        (rst),
        .divValue   (aFb_r),
        .altRange   (ctrl_r[`FTC_CTRL_DBL_A_BIT]),
        .loMin      (`FTC_FB_MIN),
        .loMax      (`FTC_FB_MAX),
        .hiMin      (`FTC_FB_DBL_MIN),
        .hiMax      (`FTC_FB_DBL_MAX),
        .bypass     (stageABypass),
        .ratio      (stageAFbRatio),
        .outOfRange (aRange)
    );

    // Stage B reference; window depends on whether stage A is bypassed.
    // A zero here passes the reference straight on to stage B's detector.
    ftc_div_stage u_b_ref ( // R7
        .clk_sys    (clk_sys),
        .rst        (rst),
        .divValue   (bRef_r),
        .altRange   (aFbNonZero),
        .loMin      (`FTC_BREF_MIN_NOA),
        .loMax      (`FTC_BREF_MAX_NOA),
        .hiMin      (`FTC_FB_MIN),
        .hiMax      (`FTC_FB_MAX),
        .bypass     (stageBRefBypass),
        .ratio      (stageBRefRatio),
        .outOfRange (bRefRange)
    );

    // Stage B feedback; window depends on the stage B doubler.
    // It mirrors stage A, with its own doubler choosing the window.
    // A zero bypasses the whole second loop, whatever its doubler says.
    ftc_div_stage u_b_fb ( // R8
        .clk_sys    (clk_sys),
        .rst        (rst),
        .divValue   (bFb_r),
        .altRange   (ctrl_r[`FTC_CTRL_DBL_B_BIT]),
        .loMin      (`FTC_FB_MIN),
        .loMax      (`FTC_FB_MAX),
        .hiMin      (`FTC_FB_DBL_MIN),
        .hiMax      (`FTC_FB_DBL_MAX),
        .bypass     (stageBBypass),
        .ratio      (stageBFbRatio),
        .outOfRange (bFbRange)
    );

    // Software-facing warning that some divider sits outside its window.
    // The flag does not change any ratio; it only tells software that the
    // present combination asks a loop to run outside its locking range.
    // Bypass codes never raise it, since a bypassed stage has no window.
    // It lags a write by two cycles: one in the stage check, one in this flag.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cfgOutOfRange <= 1'b0;
        end else begin
            cfgOutOfRange <= aRange | bRefRange | bFbRange;
        end
    end
endmodule
`default_nettype wire

// file: tb/ftc_cfg_properties.sv
// Concurrent checks on the ports of the translation configuration block.
`timescale 1ns/1ps
`default_nettype none
module ftc_cfg_properties (
    input wire logic                   clk_sys,
    input wire logic                   rst,
    input wire logic [15:0]            regAddr,
    input wire logic [7:0]             regWdata,
    input wire logic                   regWrite,
    input wire logic                   regRead,
    input wire logic [7:0]             regRdata,
    input wire logic                   regRvalid,
    input wire logic                   regHit,
    input wire logic                   stage_a_vco_doubler_en,
    input wire logic                   stage_b_vco_doubler_en,
    input wire ftc_pkg::ftc_ref_mode_t refMode,
    input wire logic                   refEnable,
    input wire logic                   stageABypass,
    input wire logic                   stageBRefBypass,
    input wire logic                   stageBBypass
);
    import ftc_pkg::*;
    // All checks share the system clock; reset aborts attempts in flight.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // Control writes reach the decoded outputs two edges later.
    sequence ctrlWr; regWrite && regAddr == 16'h0301; endsequence
    a_dbl_b_follow: assert property (ctrlWr |-> ##2
        stage_b_vco_doubler_en == $past(regWdata[5], 2)) else $error("stage B doubler wrong");
    a_dbl_a_follow: assert property (ctrlWr |-> ##2
        stage_a_vco_doubler_en == $past(regWdata[4], 2)) else $error("stage A doubler wrong");
    a_ref_off: assert property (ctrlWr |-> ##2
        refEnable == ($past(regWdata[3:0], 2) != 4'h0)) else $error("reference enable wrong");
    a_ref_double: assert property (regWrite && regAddr == 16'h0301 && regWdata[3] |-> ##2
        refMode == FTC_REF_MUL2) else $error("doubling code not decoded");
    a_ref_divide: assert property (regWrite && regAddr == 16'h0301 && !regWdata[3] &&
        regWdata[2:0] >= 3'h2 |-> ##2 refMode == $past(regWdata[3:0], 2))
        else $error("divide code not decoded");
    a_a_bypass: assert property (regWrite && regAddr == 16'h0302 |-> ##2
        stageABypass == ($past(regWdata, 2) == 8'h00)) else $error("stage A bypass wrong");
    a_bref_bypass: assert property (regWrite && regAddr == 16'h0303 |-> ##2
        stageBRefBypass == ($past(regWdata, 2) == 8'h00)) else $error("B reference bypass wrong");
    a_b_bypass: assert property (regWrite && regAddr == 16'h0304 |-> ##2
        stageBBypass == ($past(regWdata, 2) == 8'h00)) else $error("stage B bypass wrong");
    a_unused_zero: assert property (regRead && regAddr == 16'h0301 |=>
        regRvalid && regHit && regRdata[7:6] == 2'h0) else $error("unused bits not zero");
    a_read_pulse: assert property (regRead |=> regRvalid ##1 !regRvalid || $past(regRead))
        else $error("read valid not a pulse");
    cover property (regWrite && regAddr == 16'h0301 && regWdata[5:4] == 2'h3);
    cover property (regRead && regWrite);
    cover property (regRead && regAddr == 16'h0305);
endmodule
bind ftc_translation_cfg ftc_cfg_properties u_props (.clk_sys, .rst, .regAddr, .regWdata,
    .regWrite, .regRead, .regRdata, .regRvalid, .regHit, .stage_a_vco_doubler_en,
    .stage_b_vco_doubler_en, .refMode, .refEnable, .stageABypass, .stageBRefBypass,
    .stageBBypass);
`default_nettype wire

// file: tb/test_ftc_translation_cfg.sv
// Self-checking bench for the translation configuration block.
`timescale 1ns/1ps
`default_nettype none
module test_ftc_translation_cfg;
    import ftc_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [15:0] regAddr = 16'h0000;
    logic [7:0] regWdata = 8'h00, regRdata, stageAFbRatio, stageBRefRatio, stageBFbRatio;
    logic regRvalid, regHit, stage_a_vco_doubler_en, stage_b_vco_doubler_en, refEnable;
    logic stageABypass, stageBRefBypass, stageBBypass, cfgOutOfRange;
    ftc_ref_mode_t refMode;
    ftc_half_ratio_t refHalfRatio;
    logic [7:0] shC = 8'h00, shA = 8'h00, shR = 8'h00, shB = 8'h00, lfsrState = 8'h32;
    logic [7:0] v [3];
    logic [7:0] corner [10] = '{8'h00, 8'h08, 8'h50, 8'h51, 8'h0F, 8'hA1, 8'hA2, 8'h02,
                                8'h0A, 8'h07};
    int badCount = 0, nChecks = 0;
    ftc_translation_cfg dut (.clk_sys, .rst, .regAddr, .regWdata, .regWrite, .regRead,
        .regRdata, .regRvalid, .regHit, .stage_a_vco_doubler_en, .stage_b_vco_doubler_en,
        .refMode, .refHalfRatio, .refEnable, .stageABypass, .stageAFbRatio, .stageBRefBypass,
        .stageBRefRatio, .stageBBypass, .stageBFbRatio, .cfgOutOfRange);
    initial forever #5 clk_sys = ~clk_sys;
    // Expected values are derived from the shadow copies of the registers.
    function automatic logic [7:0] nextRand(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [7:0] halfOf(input logic [3:0] c);
        logic [7:0] t [8] = '{8'h00, 8'h02, 8'h03, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h10};
        return c[3] ? 8'h01 : t[c[2:0]];
    endfunction
    function automatic logic badFb(input logic [7:0] n, input logic dbl);
        return n != 8'h00 && (dbl ? (n < 8'h0F || n > 8'hA1) : (n < 8'h08 || n > 8'h50));
    endfunction
    function automatic logic badRef(input logic [7:0] r, input logic [7:0] a);
        return r != 8'h00 && (a == 8'h00 ? (r < 8'h02 || r > 8'h0A) : (r < 8'h08 || r > 8'h50));
    endfunction
    function automatic logic [7:0] expReg(input logic [15:0] a);
        case (a)
            16'h0301: return shC;
            16'h0302: return shA;
            16'h0303: return shR;
            16'h0304: return shB;
            default: return 8'h00;
        endcase
    endfunction
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        nChecks++;
        if (got !== exp) begin
            badCount++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk1(input string what, input logic exp, input logic got);
        chk(what, {7'h00, exp}, {7'h00, got});
    endtask
    // Keeps the shadow registers in step with accepted writes.
    task automatic note(input logic [15:0] a, input logic [7:0] d);
        if (a == 16'h0301) shC = d & 8'h3F;
        if (a == 16'h0302) shA = d;
        if (a == 16'h0303) shR = d;
        if (a == 16'h0304) shB = d;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk_sys);
        regWrite = 1'b0;
        note(a, d);
        repeat (2) @(negedge clk_sys);
    endtask
    task automatic rd(input logic [15:0] a);
        regAddr = a;
        regRead = 1'b1;
        @(negedge clk_sys);
        regRead = 1'b0;
        chk1("rvalid", 1'b1, regRvalid);
        chk("rdata", expReg(a), regRdata);
        chk1("hit", a >= 16'h0301 && a <= 16'h0304, regHit);
        @(negedge clk_sys);
    endtask
    task automatic checkCfg;
        chk1("dblB", shC[5], stage_b_vco_doubler_en);
        chk1("dblA", shC[4], stage_a_vco_doubler_en);
        chk1("refEn", shC[3:0] != 4'h0, refEnable);
        chk("mode", shC[3] ? 8'h08 : {4'h0, shC[3:0]}, {4'h0, refMode});
        chk("half", halfOf(shC[3:0]), {3'h0, refHalfRatio});
        chk1("aByp", shA == 8'h00, stageABypass);
        chk("aRat", shA, stageAFbRatio);
        chk1("brByp", shR == 8'h00, stageBRefBypass);
        chk("brRat", shR, stageBRefRatio);
        chk1("bByp", shB == 8'h00, stageBBypass);
        chk("bRat", shB, stageBFbRatio);
        chk1("oor", badFb(shA, shC[4]) | badRef(shR, shA) | badFb(shB, shC[5]),
             cfgOutOfRange);
    endtask
    task automatic printVerdict;
        $display("checks %0d mismatches %0d", nChecks, badCount);
        if (badCount == 0 && nChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(negedge clk_sys);
        rst = 1'b0;
        @(negedge clk_sys);
        checkCfg();
        for (int i = 0; i < 4; i++) rd(16'h0301 + i[15:0]);
        $display("test reset values done");
        // Every scaling code, with random doubler and unused bits.
        for (int i = 0; i < 16; i++) begin
            lfsrState = nextRand(lfsrState);
            wr(16'h0301, {lfsrState[7:4], i[3:0]});
            checkCfg();
            rd(16'h0301);
        end
        $display("test scaling codes done");
        // Range corners first, then random divider values.
        for (int i = 0; i < 24; i++) begin
            for (int k = 0; k < 3; k++) begin
                lfsrState = nextRand(lfsrState);
                v[k] = i < 10 ? corner[(i + 3 * k) % 10] : lfsrState;
            end
            wr(16'h0301, {2'h0, lfsrState[1:0], 4'h5});
            for (int k = 0; k < 3; k++) wr(16'h0302 + k[15:0], v[k]);
            checkCfg();
            for (int k = 0; k < 3; k++) rd(16'h0302 + k[15:0]);
        end
        $display("test dividers done");
        // Unmapped places are ignored and read as zero.
        wr(16'h0300, 8'hFF);
        wr(16'h0305, 8'hFF);
        checkCfg();
        rd(16'h0300);
        rd(16'hFFFF);
        rd(16'h0305);
        $display("test unmapped done");
        // Read and write together, then writes on consecutive cycles.
        regAddr = 16'h0302;
        regWdata = 8'h21;
        regWrite = 1'b1;
        regRead = 1'b1;
        @(negedge clk_sys);
        regRead = 1'b0;
        chk("rdOld", shA, regRdata);
        note(16'h0302, 8'h21);
        regAddr = 16'h0303;
        regWdata = 8'h05;
        @(negedge clk_sys);
        note(16'h0303, 8'h05);
        regAddr = 16'h0304;
        regWdata = 8'h00;
        @(negedge clk_sys);
        regWrite = 1'b0;
        note(16'h0304, 8'h00);
        repeat (2) @(negedge clk_sys);
        checkCfg();
        $display("test back to back done");
        // Reset in mid-run clears every written register back to zero.
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        {shC, shA, shR, shB} = 32'h00000000;
        @(negedge clk_sys);
        checkCfg();
        rd(16'h0301);
        $display("test mid reset done");
        printVerdict();
    end
endmodule
`default_nettype wire
